/* File: core/beau_pkg.sv */
// Shared constants and types for the byte EEPROM access unit
package beau_pkg;
	// Array geometry
	localparam int unsigned NV_DEPTH = 128;
	localparam int unsigned NV_ADDR_W = 7;
	localparam int unsigned NV_DATA_W = 8;
	// Special function register placement
	localparam logic [7:0] NV_ADDRESS_OFS = 8'h2C;
	localparam logic [7:0] NV_DATA_OFS = 8'h2D;
	localparam logic [7:0] NV_CONTROL_OFS = 8'h40;
	localparam logic [7:0] DIRECT_BANK = 8'h00;
	localparam logic [7:0] CONTROL_BANK = 8'h01;
	// Control register fields
	localparam int unsigned CTL_WRITE_PERMIT = 3;
	localparam int unsigned CTL_WRITE_GO = 2;
	localparam int unsigned CTL_READ_PERMIT = 1;
	localparam int unsigned CTL_READ_GO = 0;
	localparam logic [3:0] CTL_UNUSED_VAL = 4'h0;
	localparam logic ADDR_TOP_VAL = 1'b0;
	// Values after reset
	localparam logic [6:0] NV_ADDRESS_RST = 7'h00;
	localparam logic [7:0] NV_DATA_RST = 8'h00;
	localparam logic CTL_BIT_RST = 1'b0;
	localparam logic [7:0] RDATA_RST = 8'h00;
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned READ_TIME_NS = 40;
	localparam int unsigned READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RD_CNT_W = $clog2(READ_CYCLES + 1);
	localparam int unsigned TICK_NS = 1000;
	localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned WRITE_TIME_US = 2000;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b10
	} beau_state_e;
endpackage : beau_pkg

/* File: core/beau_nv_array.sv */
// Byte-wide storage array with registered read port
`timescale 1ns/1ps
module beau_nv_array #(
	parameter int unsigned DEPTH = beau_pkg::NV_DEPTH,
	parameter int unsigned ADDR_W = beau_pkg::NV_ADDR_W,
	parameter int unsigned DATA_W = beau_pkg::NV_DATA_W
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	output logic [DATA_W-1:0] rdata
);
	if (DEPTH > (1 << ADDR_W) || DEPTH < 1) begin : g_bad_depth
		$error("array depth does not fit the address width");
	end

	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] next_mem [DEPTH];
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		next_mem = mem;
		next_rdata = rdata;
		if (wr_en) begin
			next_mem[addr] = wdata;
		end
		if (rd_en) begin
			next_rdata = mem[addr];
		end
	end

	// No reset on cells: contents survive any reset
	always_ff @(posedge clk_sys) begin
		mem <= next_mem;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end
endmodule : beau_nv_array

/* File: core/beau_write_timer.sv */
// Self-timed write interval built from a microsecond tick
`timescale 1ns/1ps
module beau_write_timer #(
	parameter int unsigned WRITE_TICKS = beau_pkg::WRITE_TIME_US,
	parameter int unsigned TICK_DIV = beau_pkg::TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic start,
	output logic busy,
	output logic done
);
	if (WRITE_TICKS < 1 || TICK_DIV < 1) begin : g_bad_timer
		$error("write timer counts must be at least one");
	end

	localparam int unsigned PRE_W = $clog2(TICK_DIV + 1);
	localparam int unsigned CNT_W = $clog2(WRITE_TICKS + 1);
	localparam logic [PRE_W-1:0] PRE_LOAD = PRE_W'(TICK_DIV - 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_TICKS);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic [PRE_W-1:0] pre, next_pre;
	logic [CNT_W-1:0] remain, next_remain;
	logic next_busy, next_done;

	always_comb begin
		next_pre = pre;
		next_remain = remain;
		next_busy = busy;
		next_done = 1'b0;
		if (!busy) begin
			if (start) begin
				next_busy = 1'b1;
				next_pre = PRE_LOAD;
				next_remain = CNT_LOAD;
			end
		end else if (pre != '0) begin
			next_pre = pre - 1'b1;
		end else begin
			next_pre = PRE_LOAD;
			if (remain == CNT_ONE) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end else begin
				next_remain = remain - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pre <= '0;
			remain <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			pre <= next_pre;
			remain <= next_remain;
			busy <= next_busy;
			done <= next_done;
		end
	end
endmodule : beau_write_timer

/* File: core/beau_access_unit.sv */
// Byte EEPROM access unit: register file, read/write sequencer and checks
// Operation
// - 128 nonvolatile bytes keep contents without power
// - One byte per access via address/data registers
// - Control: permits, go bits, upper nibble zero
// - Address and data registers directly reachable, bank zero
// - Control only at 40H, bank 01H, indirectly
// - Address register seven bits, top bit zero
// - Data register eight bits read/write, reset zero
// - Read starts only if permit already high
// - Read end clears go, byte loaded
// - Data register holds until next operation
// - Write starts only if permit already high
// - Timed write ends, write go self-clears
// - Write end sets sticky done request flag
`timescale 1ns/1ps
module beau_access_unit
	import beau_pkg::*;
#(
	parameter int unsigned WRITE_TIME_US = beau_pkg::WRITE_TIME_US
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_bank,
	input wire logic sfr_indirect,
	input wire logic sfr_write,
	input wire logic sfr_read,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic nv_write_irq_enable,
	input wire logic global_irq_enable,
	input wire logic nv_write_irq_ack,
	output logic nv_write_done_flag,
	output logic nv_write_irq_req
);
	import beau_pkg::*;

	if (READ_CYCLES < 2) begin : g_bad_read
		$error("read cycle must span the array read latency");
	end

	localparam logic [RD_CNT_W-1:0] RD_LOAD = RD_CNT_W'(READ_CYCLES);
	localparam logic [RD_CNT_W-1:0] RD_ONE = RD_CNT_W'(1);

	beau_state_e state, next_state;
	logic [6:0] nv_address_reg, next_nv_address_reg;
	logic [7:0] nv_data_reg, next_nv_data_reg;
	logic write_permit, next_write_permit;
	logic write_go, next_write_go;
	logic read_permit, next_read_permit;
	logic read_go, next_read_go;
	logic [RD_CNT_W-1:0] rd_cnt, next_rd_cnt;
	logic [6:0] wr_addr, next_wr_addr;
	logic [7:0] wr_data, next_wr_data;
	logic next_done_flag;
	logic [7:0] next_sfr_rdata;

	logic addr_hit, data_hit, ctrl_hit;
	logic ctrl_wr, rd_start, wr_start, rd_done;
	logic wt_busy, wt_done;
	logic [6:0] arr_addr;
	logic [7:0] arr_rdata;
	logic [7:0] nv_control_reg;

	assign addr_hit = (sfr_bank == DIRECT_BANK) && (sfr_addr == NV_ADDRESS_OFS);
	assign data_hit = (sfr_bank == DIRECT_BANK) && (sfr_addr == NV_DATA_OFS);
	assign ctrl_hit = sfr_indirect && (sfr_bank == CONTROL_BANK) && (sfr_addr == NV_CONTROL_OFS);
	assign ctrl_wr = sfr_write && ctrl_hit;

	assign nv_control_reg = {CTL_UNUSED_VAL, write_permit, write_go, read_permit, read_go};

	assign rd_start = ctrl_wr && (state == ST_IDLE) && sfr_wdata[CTL_READ_GO] && read_permit;
	// write needs prior permit
	// Read wins if both go bits arrive together
	assign wr_start = ctrl_wr && (state == ST_IDLE) && sfr_wdata[CTL_WRITE_GO] && write_permit && !rd_start;
	assign rd_done = (state == ST_READ) && (rd_cnt == RD_ONE);

	// Write uses the address captured at start, so later edits are harmless
	assign arr_addr = (state == ST_WRITE) ? wr_addr : nv_address_reg;

	beau_nv_array #(
		.DEPTH(NV_DEPTH),
		.ADDR_W(NV_ADDR_W),
		.DATA_W(NV_DATA_W)
	) u_array (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.wr_en(wt_done),
		.rd_en(rd_start),
		.addr(arr_addr),
		.wdata(wr_data),
		.rdata(arr_rdata)
	);

	beau_write_timer #(
		.WRITE_TICKS(WRITE_TIME_US),
		.TICK_DIV(TICK_CYCLES)
	) u_timer (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.start(wr_start),
		.busy(wt_busy),
		.done(wt_done)
	);

	always_comb begin
		next_state = state;
		next_rd_cnt = rd_cnt;
		next_write_permit = write_permit;
		next_read_permit = read_permit;
		next_write_go = write_go;
		next_read_go = read_go;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		if (ctrl_wr) begin
			next_write_permit = sfr_wdata[CTL_WRITE_PERMIT];
			next_read_permit = sfr_wdata[CTL_READ_PERMIT];
		end
		case (state)
			ST_IDLE: begin
				if (rd_start) begin
					next_state = ST_READ;
					next_read_go = 1'b1;
					next_rd_cnt = RD_LOAD;
				end else if (wr_start) begin
					next_state = ST_WRITE;
					next_write_go = 1'b1;
					next_wr_addr = nv_address_reg;
					next_wr_data = nv_data_reg;
				end
			end
			ST_READ: begin
				next_rd_cnt = rd_cnt - 1'b1;
				if (rd_done) begin
					next_state = ST_IDLE;
					next_read_go = 1'b0;
				end
			end
			ST_WRITE: begin
				if (wt_done) begin
					next_state = ST_IDLE;
					next_write_go = 1'b0;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_read_go = 1'b0;
				next_write_go = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			rd_cnt <= '0;
			write_permit <= CTL_BIT_RST;
			read_permit <= CTL_BIT_RST;
			write_go <= CTL_BIT_RST;
			read_go <= CTL_BIT_RST;
			wr_addr <= NV_ADDRESS_RST;
			wr_data <= NV_DATA_RST;
		end else begin
			state <= next_state;
			rd_cnt <= next_rd_cnt;
			write_permit <= next_write_permit;
			read_permit <= next_read_permit;
			write_go <= next_write_go;
			read_go <= next_read_go;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
		end
	end

	always_comb begin
		next_nv_address_reg = nv_address_reg;
		next_nv_data_reg = nv_data_reg;
		next_done_flag = nv_write_done_flag;
		next_sfr_rdata = sfr_rdata;
		if (sfr_write && addr_hit) begin
			next_nv_address_reg = sfr_wdata[6:0];
		end
		if (sfr_write && data_hit) begin
			next_nv_data_reg = sfr_wdata;
		end
		if (rd_done) begin
			next_nv_data_reg = arr_rdata;
		end
		if (nv_write_irq_ack) begin
			next_done_flag = 1'b0;
		end
		if (wt_done) begin
			next_done_flag = 1'b1;
		end
		// Readback holds until the next read; unmapped reads give zero
		if (sfr_read) begin
			if (addr_hit) begin
				next_sfr_rdata = {ADDR_TOP_VAL, nv_address_reg};
			end else if (data_hit) begin
				next_sfr_rdata = nv_data_reg;
			end else if (ctrl_hit) begin
				next_sfr_rdata = nv_control_reg;
			end else begin
				next_sfr_rdata = RDATA_RST;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			nv_address_reg <= NV_ADDRESS_RST;
			nv_data_reg <= NV_DATA_RST;
			nv_write_done_flag <= 1'b0;
			sfr_rdata <= RDATA_RST;
		end else begin
			nv_address_reg <= next_nv_address_reg;
			nv_data_reg <= next_nv_data_reg;
			nv_write_done_flag <= next_done_flag;
			sfr_rdata <= next_sfr_rdata;
		end
	end

	assign nv_write_irq_req = nv_write_done_flag && nv_write_irq_enable && global_irq_enable;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	sequence s_read_busy;
		read_go[*4];
	endsequence

	sequence s_read_end;
		!read_go && (state == ST_IDLE);
	endsequence

	property p_ctrl_read;
		sfr_read && ctrl_hit |=> sfr_rdata[7:4] == 4'h0 && sfr_rdata[3:0] ==
			{$past(write_permit), $past(write_go), $past(read_permit), $past(read_go)};
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

	property p_addr_read;
		sfr_read && addr_hit |=> sfr_rdata == {1'b0, $past(nv_address_reg)};
	endproperty
	a_addr_read: assert property (p_addr_read) else $error("address readback wrong");

	property p_direct_ctrl;
		sfr_write && !sfr_indirect |=> $stable(write_permit) && $stable(read_permit);
	endproperty
	a_direct_ctrl: assert property (p_direct_ctrl) else $error("control changed by direct access");

	property p_read_start;
		ctrl_wr && (state == ST_IDLE) && sfr_wdata[0] |=> read_go == $past(read_permit);
	endproperty
	a_read_start: assert property (p_read_start) else $error("read start ignores permit");

	// Figure matches READ_CYCLES
	property p_read_len;
		$rose(read_go) |-> s_read_busy ##1 s_read_end;
	endproperty
	a_read_len: assert property (p_read_len) else $error("read cycle length wrong");

	property p_read_data;
		$fell(read_go) |-> nv_data_reg == $past(arr_rdata);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read byte not loaded");

	property p_data_hold;
		!(sfr_write && data_hit) && !rd_done |=> $stable(nv_data_reg);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data register changed");

	property p_write_start;
		ctrl_wr && (state == ST_IDLE) && sfr_wdata[2] && !sfr_wdata[0] |=> write_go == $past(write_permit);
	endproperty
	a_write_start: assert property (p_write_start) else $error("write start ignores permit");

	property p_write_end;
		wt_done |=> !write_go && nv_write_done_flag;
	endproperty
	a_write_end: assert property (p_write_end) else $error("write end not signalled");

	property p_flag_clear;
		nv_write_irq_ack && !wt_done |=> !nv_write_done_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("done flag not cleared by service");

	property p_busy_ignore;
		read_go || write_go |=> !$rose(read_go) && !$rose(write_go);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("go accepted while busy");

	property p_irq_req;
		nv_write_irq_req |-> nv_write_done_flag && nv_write_irq_enable && global_irq_enable;
	endproperty
	a_irq_req: assert property (p_irq_req) else $error("request raised without enables");

	property p_timer_tracks;
		write_go |-> wt_busy || wt_done;
	endproperty
	a_timer_tracks: assert property (p_timer_tracks) else $error("write go without timer");
endmodule : beau_access_unit

/* File: tb/beau_core_model.sv */
// Processor core model issuing register instructions to the access unit
`timescale 1ns/1ps
module beau_core_model (
	input wire logic clk_sys,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_bank,
	output logic sfr_indirect,
	output logic sfr_write,
	output logic sfr_read,
	output logic [7:0] sfr_wdata,
	output logic nv_write_irq_enable,
	output logic global_irq_enable,
	output logic nv_write_irq_ack
);
	import beau_pkg::*;
	initial begin
		sfr_addr = 8'h00;
		sfr_bank = 8'h00;
		sfr_indirect = 1'b0;
		sfr_write = 1'b0;
		sfr_read = 1'b0;
		sfr_wdata = 8'h00;
		nv_write_irq_enable = 1'b1;
		global_irq_enable = 1'b1;
		nv_write_irq_ack = 1'b0;
	end
	// One instruction: 0 address, 1 data, 2 control, 3 unmapped, 4 control direct
	task automatic instr(input int place, input logic wr, input logic [7:0] wd);
		@(posedge clk_sys);
		sfr_bank <= DIRECT_BANK;
		sfr_indirect <= 1'b0;
		case (place)
			0: sfr_addr <= NV_ADDRESS_OFS;
			1: sfr_addr <= NV_DATA_OFS;
			2: begin
				sfr_addr <= NV_CONTROL_OFS;
				sfr_bank <= CONTROL_BANK;
				sfr_indirect <= 1'b1;
			end
			3: sfr_addr <= 8'h30;
			default: begin
				sfr_addr <= NV_CONTROL_OFS;
				sfr_bank <= CONTROL_BANK;
			end
		endcase
		sfr_write <= wr;
		sfr_read <= ~wr;
		sfr_wdata <= wd;
		@(posedge clk_sys);
		sfr_write <= 1'b0;
		sfr_read <= 1'b0;
		// Released data bus shows garbage, not the last byte
		sfr_wdata <= ~wd;
	endtask : instr
	// address first, then permit, then go
	task automatic nv_read(input logic [6:0] a);
		instr(0, 1'b1, {1'b0, a});
		instr(2, 1'b1, 8'h02);
		instr(2, 1'b1, 8'h03);
	endtask : nv_read
	// permit then go, interrupts masked around the pair
	task automatic nv_write(input logic [6:0] a, input logic [7:0] d);
		instr(0, 1'b1, {1'b0, a});
		instr(1, 1'b1, d);
		@(posedge clk_sys);
		global_irq_enable <= 1'b0;
		instr(2, 1'b1, 8'h08);
		instr(2, 1'b1, 8'h0C);
		@(posedge clk_sys);
		global_irq_enable <= 1'b1;
	endtask : nv_write
	task automatic service(input logic ie);
		@(posedge clk_sys);
		nv_write_irq_enable <= ie;
		nv_write_irq_ack <= 1'b1;
		@(posedge clk_sys);
		nv_write_irq_ack <= 1'b0;
		nv_write_irq_enable <= 1'b1;
	endtask : service
endmodule : beau_core_model

/* File: tb/beau_access_unit_tb.sv */
// Self-checking bench for the byte EEPROM access unit
`timescale 1ns/1ps
module beau_access_unit_tb;
	import beau_pkg::*;
	// Short write interval keeps the run brief
	localparam int unsigned WR_US = 1;
	logic clk_sys;
	logic reset_n;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_bank;
	logic sfr_indirect;
	logic sfr_write;
	logic sfr_read;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic nv_write_irq_enable;
	logic global_irq_enable;
	logic nv_write_irq_ack;
	logic nv_write_done_flag;
	logic nv_write_irq_req;
	int errors = 0;
	int comparisons = 0;
	int seed = 63226;
	int cycles = 0;
	logic [7:0] exp_q[$];
	logic rd_q = 1'b0;
	logic [6:0] addrs[4];
	logic [7:0] mem[4];
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	beau_core_model core (.clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_bank(sfr_bank),
		.sfr_indirect(sfr_indirect), .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_wdata(sfr_wdata),
		.nv_write_irq_enable(nv_write_irq_enable), .global_irq_enable(global_irq_enable),
		.nv_write_irq_ack(nv_write_irq_ack));
	beau_access_unit #(.WRITE_TIME_US(WR_US)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.sfr_addr(sfr_addr), .sfr_bank(sfr_bank), .sfr_indirect(sfr_indirect), .sfr_write(sfr_write),
		.sfr_read(sfr_read), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.nv_write_irq_enable(nv_write_irq_enable), .global_irq_enable(global_irq_enable),
		.nv_write_irq_ack(nv_write_irq_ack), .nv_write_done_flag(nv_write_done_flag),
		.nv_write_irq_req(nv_write_irq_req));
	task automatic close_out();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: read %h expected %h", $time, got, exp);
		end
	endtask : check_byte
	task automatic check_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic rd(input int place, input logic [7:0] exp);
		exp_q.push_back(exp);
		core.instr(place, 1'b0, 8'h00);
	endtask : rd
	task automatic wait_done();
		int n;
		for (n = 0; n < 400 && nv_write_done_flag !== 1'b1; n++) begin
			@(posedge clk_sys);
		end
	endtask : wait_done
	// Read data lands one edge after the strobe; pair it with the oldest note
	always @(posedge clk_sys) begin
		if (rd_q) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("mismatch at %0t: unexpected read result", $time);
			end else begin
				check_byte(sfr_rdata, exp_q.pop_front());
			end
		end
		rd_q <= sfr_read;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("mismatch at %0t: run timed out", $time);
			close_out();
		end
	end
	initial begin
		reset_n = 1'b0;
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(0, 8'h00);
		rd(1, 8'h00);
		rd(2, 8'h00);
		rd(3, 8'h00);
		core.instr(0, 1'b1, 8'hFF);
		rd(0, 8'h7F);
		core.instr(1, 1'b1, 8'hA5);
		rd(1, 8'hA5);
		core.instr(2, 1'b1, 8'h01);
		rd(2, 8'h00);
		core.instr(2, 1'b1, 8'h04);
		rd(2, 8'h00);
		core.instr(2, 1'b1, 8'hF2);
		rd(2, 8'h02);
		core.instr(4, 1'b1, 8'h0A);
		rd(2, 8'h02);
		core.instr(2, 1'b1, 8'h00);
		addrs[0] = 7'h00;
		addrs[1] = 7'h7F;
		for (int i = 0; i < 4; i++) begin
			if (i > 1) begin
				// Top bits from the index, with 7'h60 in place of a repeat of 7'h7F, keep the four locations distinct
				addrs[i] = {2'(i), 5'($random(seed))};
				if (addrs[i] == addrs[1]) begin
					addrs[i] = 7'h60;
				end
			end
			mem[i] = 8'($random(seed));
			core.nv_write(addrs[i], mem[i]);
			rd(2, 8'h0C);
			// Go during a running write must not start a read
			core.instr(2, 1'b1, 8'h0F);
			rd(2, 8'h0E);
			wait_done();
			check_bit(nv_write_done_flag, 1'b1);
			rd(2, 8'h0A);
			check_bit(nv_write_irq_req, 1'b1);
			fork
				core.service(1'b0);
				begin
					// Enable dropped while the flag still stands
					@(posedge clk_sys);
					@(negedge clk_sys);
					check_bit(nv_write_done_flag, 1'b1);
					check_bit(nv_write_irq_req, 1'b0);
				end
			join
			// Clear lands on the ack edge; look once it has settled
			@(negedge clk_sys);
			check_bit(nv_write_done_flag, 1'b0);
			check_bit(nv_write_irq_req, 1'b0);
		end
		for (int i = 3; i >= 0; i--) begin
			core.instr(1, 1'b1, ~mem[i]);
			core.nv_read(addrs[i]);
			// poll read go until low, then use data
			rd(2, 8'h03);
			rd(2, 8'h03);
			rd(2, 8'h02);
			rd(1, mem[i]);
			core.instr(0, 1'b1, 8'h15);
			rd(1, mem[i]);
			rd(0, 8'h15);
		end
		repeat (4) @(posedge clk_sys);
		check_bit(exp_q.size() == 0, 1'b1);
		close_out();
	end
endmodule : beau_access_unit_tb
